// ===== hdl/nco_pkg.sv
package nco_pkg;
   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [7:0] OFS_CON = 8'h00;
   localparam logic [7:0] OFS_CLK = 8'h04;
   localparam logic [7:0] OFS_ACCL = 8'h08;
   localparam logic [7:0] OFS_ACCH = 8'h0C;
   localparam logic [7:0] OFS_ACCU = 8'h10;
   localparam logic [7:0] OFS_INCL = 8'h14;
   localparam logic [7:0] OFS_INCH = 8'h18;
   localparam logic [7:0] OFS_IRQ = 8'h1C;
   // ----------------------------------------
   // control register fields
   // ----------------------------------------
   localparam int CON_EN_BIT = 7;
   localparam int CON_OE_BIT = 6;
   localparam int CON_OUT_BIT = 5;
   localparam int CON_POL_BIT = 4;
   localparam int CON_PFM_BIT = 0;
   // ----------------------------------------
   // clock register fields
   // ----------------------------------------
   localparam int CLK_PWS_LSB = 5;
   localparam int CLK_CKS_LSB = 0;
   // ----------------------------------------
   // interrupt register fields
   // ----------------------------------------
   localparam int IRQ_FLAG_BIT = 0;
   localparam int IRQ_IE_BIT = 1;
   // ----------------------------------------
   // widths and reset values
   // ----------------------------------------
   localparam int ACC_W = 20;
   localparam int INC_W = 16;
   localparam int PCNT_W = 8;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [19:0] ACC_RESET = 20'h00000;
   localparam logic [15:0] INC_RESET = 16'h0000;
   // ----------------------------------------
   // clock source codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      CKS_EXT_PIN = 2'h0,
      CKS_SYS_OSC = 2'h1,
      CKS_HF_OSC = 2'h2,
      CKS_LOGIC_CELL = 2'h3
   } clk_src_t;
endpackage

// ===== hdl/nco_core.sv
// Overview of operation
// - 20-bit accumulator, three byte registers
// - each selected clock rising edge adds increment
// - adder carry is the raw overflow event
// - 16-bit increment from low/high byte registers
// - hidden active buffer, immediate when disabled
// - enabled: low byte write loads on tick
// - four clock sources chosen by select field
// - fixed duty mode toggles on overflow
// - pulse select bit chooses the mode
// - pulse mode: active for width, then inactive
// - pulse goes active on overflow edge
// - three-bit field gives pulse width
// - polarity bit inverts the final output
// - polarity change raises interrupt if enabled
// - output level readable and exported
// - overflow sets the interrupt flag
// - flag stays set until software clears
// - reset clears every register
// - counting sources sampled and edge-detected on clk
// - hf oscillator kept on when selected while module enabled
// - source codes 11/10/01/00 decoded
// - width is two to the code periods
// - block runs only with module enable
// - pin driven only with pin enable
`timescale 1ns/1ps
module nco_core (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // counting clock sources
   input wire logic internal_hf_osc,
   input wire logic system_osc,
   input wire logic logic_cell_output,
   input wire logic external_clock_pin,
   // outputs
   output logic output_state,
   output logic nco_pin_out,
   output logic nco_pin_oe,
   output logic overflow_irq_flag,
   output logic hf_osc_keep_on
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic module_enable_reg;
   logic output_pin_enable_reg;
   logic output_polarity_reg;
   logic pulse_freq_select_reg;
   logic [2:0] pulse_width_select_reg;
   logic [1:0] clock_source_select_reg;
   logic [19:0] phase_accumulator_reg;
   logic [7:0] inc_low_reg;
   logic [7:0] inc_high_reg;
   logic [15:0] inc_active_reg;
   logic inc_pending_reg;
   logic flag_reg;
   logic irq_enable_reg;
   logic raw_out_reg;
   logic [7:0] pulse_cnt_reg;
   logic out_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic pin_oe_reg;
   logic hf_keep_reg;
   logic [3:0] src_sync1_reg;
   logic [3:0] src_sync2_reg;
   logic src_last_reg;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] width_count(input logic [2:0] code);
      width_count = 8'(8'h01 << code);
   endfunction

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic acc_phase;
   logic wr_en;
   logic rd_cap;
   logic addr_ok;
   logic [7:0] wbyte;
   assign acc_phase = psel & penable & pready_reg;
   assign wr_en = acc_phase & pwrite;
   assign rd_cap = psel & penable & ~pready_reg;
   assign wbyte = pwdata[7:0];
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= nco_pkg::OFS_IRQ);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic wr_con;
   logic wr_clk;
   logic wr_accl;
   logic wr_acch;
   logic wr_accu;
   logic wr_incl;
   logic wr_inch;
   logic wr_irq;
   assign wr_con = wr_en & hit(paddr, nco_pkg::OFS_CON);
   assign wr_clk = wr_en & hit(paddr, nco_pkg::OFS_CLK);
   assign wr_accl = wr_en & hit(paddr, nco_pkg::OFS_ACCL);
   assign wr_acch = wr_en & hit(paddr, nco_pkg::OFS_ACCH);
   assign wr_accu = wr_en & hit(paddr, nco_pkg::OFS_ACCU);
   assign wr_incl = wr_en & hit(paddr, nco_pkg::OFS_INCL);
   assign wr_inch = wr_en & hit(paddr, nco_pkg::OFS_INCH);
   assign wr_irq = wr_en & hit(paddr, nco_pkg::OFS_IRQ);

   // ----------------------------------------
   // apb answer: one wait state
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= rd_cap;
         pslverr_reg <= rd_cap & ~addr_ok;
      end
   end
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (paddr)
         nco_pkg::OFS_CON: rd_mux[7:0] = {module_enable_reg, output_pin_enable_reg,
            out_reg, output_polarity_reg, 3'h0, pulse_freq_select_reg};
         nco_pkg::OFS_CLK: rd_mux[7:0] = {pulse_width_select_reg, 3'h0,
            clock_source_select_reg};
         nco_pkg::OFS_ACCL: rd_mux[7:0] = phase_accumulator_reg[7:0];
         nco_pkg::OFS_ACCH: rd_mux[7:0] = phase_accumulator_reg[15:8];
         nco_pkg::OFS_ACCU: rd_mux[7:0] = {4'h0, phase_accumulator_reg[19:16]};
         nco_pkg::OFS_INCL: rd_mux[7:0] = inc_low_reg;
         nco_pkg::OFS_INCH: rd_mux[7:0] = inc_high_reg;
         nco_pkg::OFS_IRQ: rd_mux[7:0] = {6'h00, irq_enable_reg, flag_reg};
         default: rd_mux = 32'h00000000;
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= 32'h00000000;
      end else if (rd_cap) begin
         prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         module_enable_reg <= 1'b0;
         output_pin_enable_reg <= 1'b0;
         output_polarity_reg <= 1'b0;
         pulse_freq_select_reg <= 1'b0;
      end else if (wr_con) begin
         module_enable_reg <= wbyte[nco_pkg::CON_EN_BIT];
         output_pin_enable_reg <= wbyte[nco_pkg::CON_OE_BIT];
         output_polarity_reg <= wbyte[nco_pkg::CON_POL_BIT];
         pulse_freq_select_reg <= wbyte[nco_pkg::CON_PFM_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_width_select_reg <= 3'h0;
         clock_source_select_reg <= 2'h0;
      end else if (wr_clk) begin
         pulse_width_select_reg <= wbyte[nco_pkg::CLK_PWS_LSB +: 3];
         clock_source_select_reg <= wbyte[nco_pkg::CLK_CKS_LSB +: 2];
      end
   end

   // ----------------------------------------
   // clock source select and edge detect
   // ----------------------------------------
   // each source is sampled by clk, so it must stay below half the clk rate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_sync1_reg <= 4'h0;
         src_sync2_reg <= 4'h0;
      end else begin
         src_sync1_reg <= {logic_cell_output, internal_hf_osc, system_osc,
            external_clock_pin};
         src_sync2_reg <= src_sync1_reg;
      end
   end
   logic src_level;
   always_comb begin
      unique case (nco_pkg::clk_src_t'(clock_source_select_reg))
         nco_pkg::CKS_EXT_PIN: src_level = src_sync2_reg[0];
         nco_pkg::CKS_SYS_OSC: src_level = src_sync2_reg[1];
         nco_pkg::CKS_HF_OSC: src_level = src_sync2_reg[2];
         nco_pkg::CKS_LOGIC_CELL: src_level = src_sync2_reg[3];
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_last_reg <= 1'b0;
      end else begin
         src_last_reg <= src_level;
      end
   end
   // counting steps only on source rising edges, as detected by sampling on clk
   logic tick;
   assign tick = src_level & ~src_last_reg & module_enable_reg;

   // ----------------------------------------
   // increment double buffer
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inc_low_reg <= nco_pkg::BYTE_RESET;
         inc_high_reg <= nco_pkg::BYTE_RESET;
      end else begin
         if (wr_incl) begin
            inc_low_reg <= wbyte;
         end
         if (wr_inch) begin
            inc_high_reg <= wbyte;
         end
      end
   end

   // high byte must already be written when the low byte arms the load
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         inc_active_reg <= nco_pkg::INC_RESET;
         inc_pending_reg <= 1'b0;
      end else if (!module_enable_reg) begin
         inc_pending_reg <= 1'b0;
         if (wr_incl) begin
            inc_active_reg <= {inc_high_reg, wbyte};
         end else if (wr_inch) begin
            inc_active_reg <= {wbyte, inc_low_reg};
         end
      end else begin
         if (tick && inc_pending_reg) begin
            inc_active_reg <= {inc_high_reg, inc_low_reg};
         end
         inc_pending_reg <= wr_incl | (inc_pending_reg & ~tick);
      end
   end

   // ----------------------------------------
   // accumulator and adder
   // ----------------------------------------
   logic [20:0] sum;
   logic ovf;
   assign sum = {1'b0, phase_accumulator_reg} + {5'h00, inc_active_reg};
   assign ovf = tick & sum[20];
   logic sw_acc_wr;
   assign sw_acc_wr = wr_accl | wr_acch | wr_accu;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_accumulator_reg <= nco_pkg::ACC_RESET;
      end else if (sw_acc_wr) begin
         if (wr_accl) begin
            phase_accumulator_reg[7:0] <= wbyte;
         end
         if (wr_acch) begin
            phase_accumulator_reg[15:8] <= wbyte;
         end
         if (wr_accu) begin
            phase_accumulator_reg[19:16] <= wbyte[3:0];
         end
      end else if (tick) begin
         phase_accumulator_reg <= sum[19:0];
      end
   end

   // ----------------------------------------
   // output shaping
   // ----------------------------------------
   // widths longer than the overflow period simply restart on the next overflow
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         raw_out_reg <= 1'b0;
         pulse_cnt_reg <= 8'h00;
      end else if (!module_enable_reg) begin
         raw_out_reg <= 1'b0;
         pulse_cnt_reg <= 8'h00;
      end else if (!pulse_freq_select_reg) begin
         pulse_cnt_reg <= 8'h00;
         if (ovf) begin
            raw_out_reg <= ~raw_out_reg;
         end
      end else if (ovf) begin
         raw_out_reg <= 1'b1;
         pulse_cnt_reg <= 8'(width_count(pulse_width_select_reg) - 8'h01);
      end else if (tick) begin
         if (pulse_cnt_reg == 8'h00) begin
            raw_out_reg <= 1'b0;
         end else begin
            pulse_cnt_reg <= 8'(pulse_cnt_reg - 8'h01);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
         hf_keep_reg <= 1'b0;
      end else begin
         out_reg <= raw_out_reg ^ output_polarity_reg;
         pin_oe_reg <= output_pin_enable_reg;
         hf_keep_reg <= module_enable_reg &&
            (clock_source_select_reg == nco_pkg::CKS_HF_OSC);
      end
   end

   // ----------------------------------------
   // interrupt flag
   // ----------------------------------------
   logic pol_evt;
   assign pol_evt = irq_enable_reg & wr_con &
      (wbyte[nco_pkg::CON_POL_BIT] != output_polarity_reg);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_reg <= 1'b0;
         irq_enable_reg <= 1'b0;
      end else begin
         if (wr_irq) begin
            irq_enable_reg <= wbyte[nco_pkg::IRQ_IE_BIT];
         end
         // a new event in the clearing cycle keeps the flag set
         if (ovf || pol_evt) begin
            flag_reg <= 1'b1;
         end else if (wr_irq && !wbyte[nco_pkg::IRQ_FLAG_BIT]) begin
            flag_reg <= 1'b0;
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign output_state = out_reg;
   assign nco_pin_out = out_reg;
   assign nco_pin_oe = pin_oe_reg;
   assign overflow_irq_flag = flag_reg;
   assign hf_osc_keep_on = hf_keep_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_ACC_ADD: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && !sw_acc_wr) |=> phase_accumulator_reg == $past(sum[19:0]))
      else $error("accumulator did not add increment");
   AST_ACC_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (!module_enable_reg && !sw_acc_wr) |=> $stable(phase_accumulator_reg))
      else $error("accumulator moved while disabled");
   AST_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_n)
      ovf |=> flag_reg)
      else $error("overflow did not set flag");
   AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      (flag_reg && !wr_irq) |=> flag_reg)
      else $error("flag cleared without software");
   AST_FDC_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
      (ovf && !pulse_freq_select_reg) |=> raw_out_reg != $past(raw_out_reg))
      else $error("fixed duty output did not toggle");
   AST_PF_ACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
      (ovf && pulse_freq_select_reg) |=> raw_out_reg ##1 out_reg == !output_polarity_reg)
      else $error("pulse not active after overflow");
   AST_DIS_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
      !module_enable_reg |=> !raw_out_reg)
      else $error("output active while disabled");
   AST_POL_OUT: assert property (@(posedge clk) disable iff (!rst_n)
      1'b1 |=> out_reg == ($past(raw_out_reg) ^ $past(output_polarity_reg)))
      else $error("polarity stage wrong");
   AST_INC_IMM: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_incl && !module_enable_reg) |=> inc_active_reg[7:0] == $past(wbyte))
      else $error("increment not loaded at once");
   AST_PIN_OE: assert property (@(posedge clk) disable iff (!rst_n)
      !output_pin_enable_reg |=> !nco_pin_oe)
      else $error("pin driven while disabled");
endmodule

// ===== verification/nco_clock_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// counting clock source model
// ----------------------------------------
module nco_clock_model (
   // clock
   input wire logic clk,
   // counting clock sources
   output logic external_clock_pin,
   output logic system_osc,
   output logic internal_hf_osc,
   output logic logic_cell_output
);
   // index follows the source select codes; lines rest low between bursts
   logic [3:0] src_lines = 4'h0;
   assign external_clock_pin = src_lines[0];
   assign system_osc = src_lines[1];
   assign internal_hf_osc = src_lines[2];
   assign logic_cell_output = src_lines[3];
   // each level held 3 clk so the double synchroniser never misses an edge
   task automatic pulse(input int line, input int n);
      for (int i = 0; i < n; i++) begin
         src_lines[line] <= 1'b1;
         repeat (3) @(posedge clk);
         src_lines[line] <= 1'b0;
         repeat (3) @(posedge clk);
      end
      // the tick lands 3 clk after the edge, the output one later
      repeat (4) @(posedge clk);
   endtask
endmodule

// ===== verification/tb_nco_core.sv
`timescale 1ns/1ps
module tb_nco_core;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic hf_osc, sys_osc, lc_out, ext_pin;
   logic output_state, nco_pin_out, nco_pin_oe, overflow_irq_flag, hf_osc_keep_on;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   always #10 clk = ~clk;
   nco_core dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .internal_hf_osc(hf_osc), .system_osc(sys_osc), .logic_cell_output(lc_out),
      .external_clock_pin(ext_pin), .output_state(output_state), .nco_pin_out(nco_pin_out),
      .nco_pin_oe(nco_pin_oe), .overflow_irq_flag(overflow_irq_flag),
      .hf_osc_keep_on(hf_osc_keep_on));
   nco_clock_model src_model (.clk(clk), .external_clock_pin(ext_pin), .system_osc(sys_osc),
      .internal_hf_osc(hf_osc), .logic_cell_output(lc_out));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      // the full sequence needs well under 10000 cycles
      if (cycles == 40000) begin
         fails++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pchk(input logic got, input logic exp);
      check({31'h0, got}, {31'h0, exp});
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, {24'h0, exp});
   endtask
   task automatic acc_set(input logic [19:0] v);
      wr(nco_pkg::OFS_ACCL, v[7:0]);
      wr(nco_pkg::OFS_ACCH, v[15:8]);
      wr(nco_pkg::OFS_ACCU, {4'h0, v[19:16]});
   endtask
   task automatic acc_chk(input logic [19:0] v);
      rd_chk(nco_pkg::OFS_ACCL, v[7:0]);
      rd_chk(nco_pkg::OFS_ACCH, v[15:8]);
      rd_chk(nco_pkg::OFS_ACCU, {4'h0, v[19:16]});
   endtask
   task automatic inc_set(input logic [15:0] v);
      wr(nco_pkg::OFS_INCH, v[15:8]);
      wr(nco_pkg::OFS_INCL, v[7:0]);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset();
      logic [31:0] r;
      logic e;
      for (int a = 0; a <= 28; a += 4) rd_chk(8'(a), 8'h00);
      apb(1'b0, 8'h20, 32'h0, r, e);
      check(r, 32'h0);
      pchk(e, 1'b1);
      pchk(output_state, 1'b0);
      $display("test_reset done");
   endtask
   task automatic test_regs();
      inc_set(16'h1234);
      rd_chk(nco_pkg::OFS_INCL, 8'h34);
      rd_chk(nco_pkg::OFS_INCH, 8'h12);
      acc_set(20'h5ABCD);
      wr(nco_pkg::OFS_ACCU, 8'hF5);
      acc_chk(20'h5ABCD);
      wr(nco_pkg::OFS_CLK, 8'hFF);
      rd_chk(nco_pkg::OFS_CLK, 8'hE3);
      wr(nco_pkg::OFS_CON, 8'h0E);
      rd_chk(nco_pkg::OFS_CON, 8'h00);
      wr(nco_pkg::OFS_CLK, 8'h00);
      src_model.pulse(0, 2);
      acc_chk(20'h5ABCD);
      pchk(overflow_irq_flag, 1'b0);
      $display("test_regs done");
   endtask
   task automatic test_overflow();
      acc_set(20'hFFFF0);
      inc_set(16'h0020);
      wr(nco_pkg::OFS_CON, 8'h80);
      src_model.pulse(0, 1);
      acc_chk(20'h00010);
      pchk(overflow_irq_flag, 1'b1);
      pchk(output_state, 1'b1);
      rd_chk(nco_pkg::OFS_CON, 8'hA0);
      src_model.pulse(0, 1);
      acc_chk(20'h00030);
      pchk(output_state, 1'b1);
      wr(nco_pkg::OFS_IRQ, 8'h01);
      pchk(overflow_irq_flag, 1'b1);
      wr(nco_pkg::OFS_IRQ, 8'h00);
      pchk(overflow_irq_flag, 1'b0);
      $display("test_overflow done");
   endtask
   task automatic test_sources();
      wr(nco_pkg::OFS_CON, 8'h00);
      acc_set(20'h00000);
      inc_set(16'h0001);
      wr(nco_pkg::OFS_CON, 8'h80);
      for (int c = 0; c < 4; c++) begin
         wr(nco_pkg::OFS_CLK, 8'(c));
         repeat (2) @(posedge clk);
         pchk(hf_osc_keep_on, c == 2);
         for (int l = 0; l < 4; l++) if (l != c) src_model.pulse(l, 1);
         src_model.pulse(c, 2);
         acc_chk(20'(2 * (c + 1)));
      end
      $display("test_sources done");
   endtask
   task automatic test_double_buffer();
      wr(nco_pkg::OFS_INCH, 8'h01);
      src_model.pulse(3, 1);
      acc_chk(20'h00009);
      wr(nco_pkg::OFS_INCL, 8'h00);
      src_model.pulse(3, 1);
      acc_chk(20'h0000A);
      src_model.pulse(3, 1);
      acc_chk(20'h0010A);
      $display("test_double_buffer done");
   endtask
   task automatic test_pulse();
      int width;
      wr(nco_pkg::OFS_CON, 8'h00);
      inc_set(16'h0001);
      // increment 1 keeps the width far below the overflow period
      for (int k = 0; k < 8; k++) begin
         wr(nco_pkg::OFS_CON, 8'h00);
         acc_set(20'hFFFFF);
         wr(nco_pkg::OFS_CLK, 8'(k << 5));
         wr(nco_pkg::OFS_CON, 8'h81);
         pchk(output_state, 1'b0);
         src_model.pulse(0, 1);
         width = 0;
         while (output_state === 1'b1 && width < 300) begin
            width++;
            src_model.pulse(0, 1);
         end
         check(32'(width), 32'(1 << k));
      end
      $display("test_pulse done");
   endtask
   task automatic test_polarity();
      wr(nco_pkg::OFS_CON, 8'h00);
      wr(nco_pkg::OFS_IRQ, 8'h02);
      pchk(overflow_irq_flag, 1'b0);
      wr(nco_pkg::OFS_CON, 8'h50);
      repeat (2) @(posedge clk);
      pchk(output_state, 1'b1);
      pchk(nco_pin_out, 1'b1);
      pchk(nco_pin_oe, 1'b1);
      pchk(overflow_irq_flag, 1'b1);
      rd_chk(nco_pkg::OFS_CON, 8'h70);
      wr(nco_pkg::OFS_CON, 8'h00);
      repeat (2) @(posedge clk);
      pchk(nco_pin_oe, 1'b0);
      pchk(output_state, 1'b0);
      $display("test_polarity done");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      test_reset();
      test_regs();
      test_overflow();
      test_sources();
      test_double_buffer();
      test_pulse();
      test_polarity();
      complete_run();
   end
endmodule
